/* design/eemr_pkg.sv */
// Package of constants and types for the error event message router.
// Contract
// - Enabled error flag sends system-error message on link.
// - Global command enable gates every system-error message.
// - Enable bit 11 reports thermal trip as system-error.
// - Enable bit 9 reports locked non-DRAM access.
// - Enable bit 8 reports refresh timeout.
// - Enable bit 1 reports multiple-bit ECC as system-error.
// - Enable bit 0 reports single-bit ECC as system-error.
// - Management bit 1 sends management message on multi-bit.
// - Management bit 0 sends management message on single-bit.
// - Control bit 1 sends control message on multi-bit.
// - Control bit 0 sends control message on single-bit.
// - Set thermal flag blocks further thermal messages.
// - Refresh timeout flag sets at 1024 queued refreshes.
// - Status flags sticky, write-one-clear, power-good reset.
`default_nettype none
package eemr_pkg;

  // ----------------------------------------------------------------
  // Configuration register offsets and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] EEMR_OFF_STATUS = 8'hC8;
  localparam logic [7:0] EEMR_OFF_SERR_EN = 8'hCA;
  localparam logic [7:0] EEMR_OFF_MGMT_EN = 8'hCC;
  localparam logic [7:0] EEMR_OFF_CTRL_EN = 8'hCE;
  localparam logic [15:0] EEMR_RESET_VAL = 16'h0000;
  localparam logic [15:0] EEMR_SERR_MASK = 16'h0B03;
  localparam logic [15:0] EEMR_ECC_MASK = 16'h0003;
  localparam logic [15:0] EEMR_STATUS_MASK = 16'h0B03;

  // ----------------------------------------------------------------
  // Field positions within the status and enable registers
  // ----------------------------------------------------------------
  localparam int EEMR_BIT_THERMAL = 11;
  localparam int EEMR_BIT_LOCK = 9;
  localparam int EEMR_BIT_REFRESH = 8;
  localparam int EEMR_BIT_MULTI = 1;
  localparam int EEMR_BIT_SINGLE = 0;

  // ----------------------------------------------------------------
  // Refresh watchdog count
  // ----------------------------------------------------------------
  localparam int EEMR_REFRESH_W = 11;
  localparam logic [10:0] EEMR_REFRESH_LIMIT = 11'h0400;
  localparam logic [10:0] EEMR_REFRESH_ZERO = 11'h0000;
  localparam logic [10:0] EEMR_REFRESH_ONE = 11'h0001;

  // ----------------------------------------------------------------
  // Message kinds sent over the chipset link
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EEMR_MSG_SERR = 3'b001,
    EEMR_MSG_MGMT = 3'b010,
    EEMR_MSG_CTRL = 3'b100
  } eemr_kind_t;

  typedef struct packed {
    logic valid;
    eemr_kind_t kind;
  } eemr_msg_t;

  // Raw error events from the memory controller side.
  typedef struct packed {
    logic thermal_trip;
    logic nondram_lock;
    logic multibit_ecc;
    logic singlebit_ecc;
  } eemr_event_t;

endpackage
`default_nettype wire

/* design/eemr_refresh_watch.sv */
// Refresh timeout watchdog counting queued but unissued refreshes.
`timescale 1ns/1ps
`default_nettype none
module eemr_refresh_watch
  import eemr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refresh_queued,
  input wire logic refresh_issued,
  output logic timeout_q
);

  logic [EEMR_REFRESH_W-1:0] count_q;
  logic [EEMR_REFRESH_W-1:0] count_d;

  // Net backlog; saturates so a stuck controller cannot wrap back to zero.
  always_comb begin
    count_d = count_q;
    if (refresh_queued && !refresh_issued && count_q != EEMR_REFRESH_LIMIT) begin
      count_d = count_q + EEMR_REFRESH_ONE;
    end else if (refresh_issued && !refresh_queued && count_q != EEMR_REFRESH_ZERO) begin
      count_d = count_q - EEMR_REFRESH_ONE;
    end
  end

  // Backlog register and timeout level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= EEMR_REFRESH_ZERO;
      timeout_q <= 1'b0;
    end else begin
      count_q <= count_d;
      timeout_q <= (count_d == EEMR_REFRESH_LIMIT);
    end
  end

  a_refresh_limit: assert property (@(posedge clk) disable iff (!rst_n)
    (count_q == EEMR_REFRESH_LIMIT) |-> timeout_q)
    else $error("Refresh timeout not raised at backlog limit.");

endmodule
`default_nettype wire

/* design/eemr_router.sv */
// Error event message router: enable registers, sticky flags, link queue.
`timescale 1ns/1ps
`default_nettype none
module eemr_router
  import eemr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  input wire logic serr_global_en,
  input wire eemr_event_t err_event,
  input wire logic refresh_queued,
  input wire logic refresh_issued,
  output eemr_msg_t link_msg_q,
  input wire logic link_ready
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  // Assertion is immediate, release waits two edges to avoid metastability.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration access
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:1] == off[7:1]);
  endfunction

  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  logic [15:0] serr_en_q;
  logic [15:0] mgmt_en_q;
  logic [15:0] ctrl_en_q;
  logic [15:0] flags_q;
  logic [15:0] flags_set;
  logic [15:0] flags_clr;
  logic [15:0] wmask;
  logic refresh_timeout;

  assign wmask = lane_mask(cfg_be) & cfg_wdata;

  // Enable registers; reserved bits never store, so they read as zero.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serr_en_q <= EEMR_RESET_VAL;
      mgmt_en_q <= EEMR_RESET_VAL;
      ctrl_en_q <= EEMR_RESET_VAL;
    end else if (cfg_wr) begin
      if (reg_hit(cfg_addr, EEMR_OFF_SERR_EN)) begin
        serr_en_q <= (serr_en_q & ~lane_mask(cfg_be))
                     | (cfg_wdata & lane_mask(cfg_be) & EEMR_SERR_MASK);
      end
      if (reg_hit(cfg_addr, EEMR_OFF_MGMT_EN)) begin
        mgmt_en_q <= (mgmt_en_q & ~lane_mask(cfg_be))
                     | (cfg_wdata & lane_mask(cfg_be) & EEMR_ECC_MASK);
      end
      if (reg_hit(cfg_addr, EEMR_OFF_CTRL_EN)) begin
        ctrl_en_q <= (ctrl_en_q & ~lane_mask(cfg_be))
                     | (cfg_wdata & lane_mask(cfg_be) & EEMR_ECC_MASK);
      end
    end
  end

  // Read data is registered; unmapped offsets answer zero.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_rdata_q <= EEMR_RESET_VAL;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      if (!cfg_rd) begin
        cfg_rdata_q <= EEMR_RESET_VAL;
      end else if (reg_hit(cfg_addr, EEMR_OFF_STATUS)) begin
        cfg_rdata_q <= flags_q;
      end else if (reg_hit(cfg_addr, EEMR_OFF_SERR_EN)) begin
        cfg_rdata_q <= serr_en_q;
      end else if (reg_hit(cfg_addr, EEMR_OFF_MGMT_EN)) begin
        cfg_rdata_q <= mgmt_en_q;
      end else if (reg_hit(cfg_addr, EEMR_OFF_CTRL_EN)) begin
        cfg_rdata_q <= ctrl_en_q;
      end else begin
        cfg_rdata_q <= EEMR_RESET_VAL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky error status flags
  // ----------------------------------------------------------------
  eemr_refresh_watch u_refresh (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .refresh_queued(refresh_queued),
    .refresh_issued(refresh_issued),
    .timeout_q(refresh_timeout)
  );

  // Event inputs come from same-clock memory controller logic.
  always_comb begin
    flags_set = EEMR_RESET_VAL;
    flags_set[EEMR_BIT_THERMAL] = err_event.thermal_trip;
    flags_set[EEMR_BIT_LOCK] = err_event.nondram_lock;
    flags_set[EEMR_BIT_REFRESH] = refresh_timeout;
    flags_set[EEMR_BIT_MULTI] = err_event.multibit_ecc;
    flags_set[EEMR_BIT_SINGLE] = err_event.singlebit_ecc;
  end

  assign flags_clr = (cfg_wr && reg_hit(cfg_addr, EEMR_OFF_STATUS)) ? wmask : EEMR_RESET_VAL;

  // A new event in the clearing cycle wins, so no error is ever lost.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags_q <= EEMR_RESET_VAL;
    end else begin
      flags_q <= ((flags_q & ~flags_clr) | flags_set) & EEMR_STATUS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Qualification and message queue
  // ----------------------------------------------------------------
  logic serr_qual;
  logic mgmt_qual;
  logic ctrl_qual;
  logic serr_prev_q;
  logic mgmt_prev_q;
  logic ctrl_prev_q;
  logic serr_rise;
  logic mgmt_rise;
  logic ctrl_rise;
  logic serr_pend_q;
  logic mgmt_pend_q;
  logic ctrl_pend_q;
  logic take;

  // A thermal flag left set keeps the qualifier high, so no new edge.
  assign serr_qual = |(flags_q & serr_en_q)
                     && serr_global_en;
  assign mgmt_qual = |(flags_q & mgmt_en_q);
  assign ctrl_qual = |(flags_q & ctrl_en_q);
  assign serr_rise = serr_qual && !serr_prev_q;
  assign mgmt_rise = mgmt_qual && !mgmt_prev_q;
  assign ctrl_rise = ctrl_qual && !ctrl_prev_q;
  assign take = !link_msg_q.valid || link_ready;

  // Edge history and pending bits; a rise beats the load that clears.
  // Repeated rises of one kind while it waits merge into one message.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serr_prev_q <= 1'b0;
      mgmt_prev_q <= 1'b0;
      ctrl_prev_q <= 1'b0;
      serr_pend_q <= 1'b0;
      mgmt_pend_q <= 1'b0;
      ctrl_pend_q <= 1'b0;
    end else begin
      serr_prev_q <= serr_qual;
      mgmt_prev_q <= mgmt_qual;
      ctrl_prev_q <= ctrl_qual;
      serr_pend_q <= serr_rise || (serr_pend_q && !take);
      mgmt_pend_q <= mgmt_rise || (mgmt_pend_q && !(take && !serr_pend_q));
      ctrl_pend_q <= ctrl_rise || (ctrl_pend_q && !(take && !serr_pend_q && !mgmt_pend_q));
    end
  end

  // Link output holds until accepted; system errors go first.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_msg_q.valid <= 1'b0;
      link_msg_q.kind <= EEMR_MSG_SERR;
    end else if (take) begin
      link_msg_q.valid <= serr_pend_q || mgmt_pend_q || ctrl_pend_q;
      if (serr_pend_q) begin
        link_msg_q.kind <= EEMR_MSG_SERR;
      end else if (mgmt_pend_q) begin
        link_msg_q.kind <= EEMR_MSG_MGMT;
      end else if (ctrl_pend_q) begin
        link_msg_q.kind <= EEMR_MSG_CTRL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_link_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (link_msg_q.valid && !link_ready) |=> (link_msg_q.valid && $stable(link_msg_q.kind)))
    else $error("Link message dropped before acceptance.");

  a_serr_gate: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $rose(serr_pend_q) |-> $past(serr_global_en))
    else $error("System-error queued while globally disabled.");

  a_thermal_msg: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ($rose(flags_q[EEMR_BIT_THERMAL]) && serr_en_q[EEMR_BIT_THERMAL] && serr_global_en
     && !serr_prev_q) |=> serr_pend_q)
    else $error("Thermal trip did not queue a system-error.");

  a_lock_msg: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ($rose(flags_q[EEMR_BIT_LOCK]) && serr_en_q[EEMR_BIT_LOCK] && serr_global_en
     && !serr_prev_q) |=> serr_pend_q)
    else $error("Locked access did not queue a system-error.");

  a_multi_mgmt: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ($rose(flags_q[EEMR_BIT_MULTI]) && mgmt_en_q[EEMR_BIT_MULTI] && !mgmt_prev_q)
    |=> mgmt_pend_q ##[0:3] (link_msg_q.valid && link_msg_q.kind == EEMR_MSG_MGMT)
    or ##[1:40] (link_msg_q.valid && link_msg_q.kind == EEMR_MSG_MGMT))
    else $error("Multi-bit error did not reach management message.");

  a_single_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    ($rose(flags_q[EEMR_BIT_SINGLE]) && ctrl_en_q[EEMR_BIT_SINGLE] && !ctrl_prev_q)
    |=> ctrl_pend_q)
    else $error("Single-bit error did not queue a control message.");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (flags_q[EEMR_BIT_SINGLE] && !flags_clr[EEMR_BIT_SINGLE]) |=> flags_q[EEMR_BIT_SINGLE])
    else $error("Status flag cleared without a write of one.");

  a_no_repeat: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (serr_qual && serr_prev_q && !serr_pend_q && !link_msg_q.valid) |=> !serr_pend_q)
    else $error("System-error repeated while its flag stayed set.");

  a_refresh_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    refresh_timeout |=> flags_q[EEMR_BIT_REFRESH])
    else $error("Refresh timeout did not set its status flag.");

endmodule
`default_nettype wire

/* tb/eemr_link_model.sv */
// Link-side partner that accepts router messages, promptly or with stalls.
`timescale 1ns/1ps
`default_nettype none
module eemr_link_model
  import eemr_pkg::*;
(
  input wire logic clk,
  input wire eemr_msg_t msg,
  input wire logic slow,
  output logic ready
);
  eemr_kind_t got[$];

  // ----------------------------------------------------------------
  // Accept and record
  // ----------------------------------------------------------------
  // A slow link stalls at random, so the router has to hold its message.
  initial begin
    ready = 1'b0;
    forever begin
      @(posedge clk);
      if (msg.valid && ready) begin
        got.push_back(msg.kind);
      end
      #1 ready = slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb/error_event_message_router_tb.sv */
// Self-checking bench for the error event message router.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module error_event_message_router_tb
  import eemr_pkg::*;
;
  logic ref_clk, rst_n, cfg_wr, cfg_rd, cfg_rvalid_q, serr_global_en;
  logic refresh_queued, refresh_issued, link_ready, slow;
  logic [7:0] cfg_addr;
  logic [1:0] cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata_q;
  eemr_event_t err_event;
  eemr_msg_t link_msg_q;
  int mismatches, cmp_count;
  eemr_kind_t exp_q[$];
  bit flag_set;
  bit has_msg;
  eemr_kind_t exp_kind;

  eemr_router eemr_router_inst (.ref_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata_q, .cfg_rvalid_q, .serr_global_en, .err_event,
    .refresh_queued, .refresh_issued, .link_msg_q, .link_ready);
  eemr_link_model eemr_link_model_inst (.clk(ref_clk), .msg(link_msg_q), .slow(slow),
    .ready(link_ready));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  // The whole run needs about 34k cycles, so 0.9 ms means a hang.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #900_000;
    mismatches++;
    print_verdict();
  end

  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Register access and event tasks
  // ----------------------------------------------------------------
  // Strobes are one cycle wide and always change 1 ns after an edge.
  task automatic cfg_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge ref_clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge ref_clk);
    #1 cfg_wr = 1'b0;
  endtask

  task automatic chk_read(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    #1 cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge ref_clk);
    #1 cfg_rd = 1'b0;
    `CHK(cfg_rvalid_q, 1'b1)
    `CHK(cfg_rdata_q, e)
  endtask

  // The model queues a message only when the flag was clear before the event.
  task automatic fire(input int i, input int n);
    @(posedge ref_clk);
    if (i == 2) begin
      #1 refresh_queued = 1'b1;
      repeat (1024) @(posedge ref_clk);
      #1 refresh_queued = 1'b0;
      refresh_issued = 1'b1;
      repeat (1024) @(posedge ref_clk);
      #1 refresh_issued = 1'b0;
    end else begin
      #1 err_event = eemr_event_t'(4'b0001 << (i < 2 ? 3 - i : 4 - i));
      repeat (n) @(posedge ref_clk);
      #1 err_event = '0;
    end
    if (!flag_set && has_msg) exp_q.push_back(exp_kind);
    flag_set = 1'b1;
  endtask

  task automatic settle_cmp();
    for (int k = 0; k < 80 && eemr_link_model_inst.got.size() < exp_q.size(); k++)
      @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK(eemr_link_model_inst.got.size(), exp_q.size())
    foreach (exp_q[k]) if (k < eemr_link_model_inst.got.size())
      `CHK(eemr_link_model_inst.got[k], exp_q[k])
    exp_q.delete();
    eemr_link_model_inst.got.delete();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int bits[5];
    logic [15:0] w, msk;
    logic [7:0] a;
    logic [7:0] offs[5];
    bits = '{11, 9, 8, 1, 0};
    offs = '{8'hC8, 8'hCA, 8'hCC, 8'hCE, 8'hD0};
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'hf9b7_c76c));
    {rst_n, cfg_wr, cfg_rd, serr_global_en, refresh_queued, refresh_issued, slow} = '0;
    cfg_addr = '0;
    cfg_be = '0;
    cfg_wdata = '0;
    err_event = '0;
    repeat (20) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (offs[j])
      chk_read(offs[j], 16'h0000);
    cfg_write(EEMR_OFF_SERR_EN, 2'b01, 16'hffff);
    chk_read(EEMR_OFF_SERR_EN, 16'h0003);
    cfg_write(EEMR_OFF_SERR_EN, 2'b10, 16'hffff);
    chk_read(EEMR_OFF_SERR_EN, 16'h0b03);
    // One backlog short of the limit must not raise the timeout flag.
    @(posedge ref_clk);
    #1 refresh_queued = 1'b1;
    repeat (1023) @(posedge ref_clk);
    #1 refresh_queued = 1'b0;
    repeat (5) @(posedge ref_clk);
    chk_read(EEMR_OFF_STATUS, 16'h0000);
    @(posedge ref_clk);
    #1 refresh_issued = 1'b1;
    repeat (1023) @(posedge ref_clk);
    #1 refresh_issued = 1'b0;
    // Each flag against each message path; only one path is enabled at a time.
    for (int i = 0; i < 5; i++) begin
      for (int m = 0; m < 5; m++) begin
        cfg_write(EEMR_OFF_SERR_EN, 2'b11, 16'h0000);
        cfg_write(EEMR_OFF_MGMT_EN, 2'b11, 16'h0000);
        cfg_write(EEMR_OFF_CTRL_EN, 2'b11, 16'h0000);
        a = (m == 2) ? EEMR_OFF_MGMT_EN : (m == 3) ? EEMR_OFF_CTRL_EN : EEMR_OFF_SERR_EN;
        msk = (m >= 2) ? EEMR_ECC_MASK : EEMR_SERR_MASK;
        w = (16'h0001 << bits[i]) | (16'($urandom) & 16'hf4fc);
        if (m < 4) cfg_write(a, 2'b11, w);
        if (m < 4) chk_read(a, w & msk);
        serr_global_en = (m != 1);
        slow = 1'($urandom_range(1));
        has_msg = (m == 0) || (m >= 2 && m < 4 && bits[i] < 2);
        exp_kind = (m == 2) ? EEMR_MSG_MGMT : (m == 3) ? EEMR_MSG_CTRL : EEMR_MSG_SERR;
        flag_set = 1'b0;
        fire(i, 1);
        fire(i, 3);
        settle_cmp();
        chk_read(EEMR_OFF_STATUS, 16'h0001 << bits[i]);
        cfg_write(EEMR_OFF_STATUS, 2'b11, 16'h0001 << bits[i]);
        chk_read(EEMR_OFF_STATUS, 16'h0000);
        flag_set = 1'b0;
        fire(i, 1);
        settle_cmp();
        cfg_write(EEMR_OFF_STATUS, 2'b11, 16'h0001 << bits[i]);
      end
    end
    // Power-good reset in mid-run must drop enables, sticky flags and the link output.
    cfg_write(EEMR_OFF_CTRL_EN, 2'b11, 16'h0003);
    fire(3, 1);
    chk_read(EEMR_OFF_STATUS, 16'h0002);
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(link_msg_q, {1'b0, EEMR_MSG_SERR})
    chk_read(EEMR_OFF_CTRL_EN, 16'h0000);
    chk_read(EEMR_OFF_STATUS, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
